//--- src/bsq_pkg.sv
`default_nettype none

package bsq_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] BSQ_OFS_CTRL        = 8'h00;
    localparam logic [7:0] BSQ_OFS_START_PHASE = 8'h04;
    localparam logic [7:0] BSQ_OFS_PHASE_STEP  = 8'h08;
    localparam logic [7:0] BSQ_OFS_HALVES      = 8'h0C;
    localparam logic [7:0] BSQ_OFS_START_DELAY = 8'h10;
    localparam logic [7:0] BSQ_OFS_TRIG_PERIOD = 8'h14;
    localparam logic [7:0] BSQ_OFS_IDLE_LEVEL  = 8'h18;
    localparam logic [7:0] BSQ_OFS_COMMAND     = 8'h1C;
    localparam logic [7:0] BSQ_OFS_STATUS      = 8'h20;
    localparam logic [7:0] BSQ_OFS_REMAIN      = 8'h24;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] BSQ_RST_CTRL        = 32'h0000_0000;
    localparam logic [31:0] BSQ_RST_START_PHASE = 32'h0000_0000;
    localparam logic [31:0] BSQ_RST_PHASE_STEP  = 32'h0001_0000;
    localparam logic [31:0] BSQ_RST_HALVES      = 32'h0000_0002;
    localparam logic [31:0] BSQ_RST_START_DELAY = 32'h0000_0000;
    localparam logic [31:0] BSQ_RST_TRIG_PERIOD = 32'h0001_86A0;
    localparam logic [7:0]  BSQ_RST_IDLE_LEVEL  = 8'h00;

    // command register: bit position of the remote trigger
    localparam int unsigned BSQ_CMD_REMOTE_BIT = 0;

    // ------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BSQ_MODE_CONT,
        BSQ_MODE_TRIG,
        BSQ_MODE_GATE,
        BSQ_MODE_RSVD
    } bsq_mode_t;

    typedef enum logic [1:0] {
        BSQ_SRC_INT,
        BSQ_SRC_EXT,
        BSQ_SRC_FIRST_CHANNEL_SHARED,
        BSQ_SRC_RSVD
    } bsq_src_t;

    typedef enum logic [1:0] {
        BSQ_POL_OFF,
        BSQ_POL_RISE,
        BSQ_POL_FALL,
        BSQ_POL_RSVD
    } bsq_pol_t;

    typedef enum logic [2:0] {
        BSQ_WAVE_SINE,
        BSQ_WAVE_SQUARE,
        BSQ_WAVE_TRIANGLE,
        BSQ_WAVE_RAMP_UP,
        BSQ_WAVE_RAMP_DOWN,
        BSQ_WAVE_ARB,
        BSQ_WAVE_NOISE,
        BSQ_WAVE_DC
    } bsq_wave_t;

    typedef enum logic [2:0] {
        BSQ_AUX_PHASE_MARK,
        BSQ_AUX_BURST_GATE_INDICATOR,
        BSQ_AUX_MODULATION_REF_MARKER,
        BSQ_AUX_WAVEFORM_OUT,
        BSQ_AUX_OFF
    } bsq_aux_t;

    // ------------------------------------------------------------------
    // control register layout
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] rsvd;
        logic        freq_lock;
        logic        mod_int_on;
        bsq_aux_t    aux_output_select;
        bsq_wave_t   wave;
        logic        half_stop;
        logic        idle_level_override;
        bsq_pol_t    ext_pol;
        bsq_src_t    src;
        bsq_mode_t   pulse_group_type;
    } bsq_ctrl_t;

endpackage : bsq_pkg

`default_nettype wire

//--- src/bsq_tick_gen.sv
`default_nettype none

module bsq_tick_gen #(
    parameter int unsigned W = 32
) (
    // clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_b,
    // control
    input  wire logic         i_en,
    input  wire logic [W-1:0] i_period,
    // outputs
    output logic              o_tick,
    output logic              o_level
);

    if (W < 2) begin : g_bad_width
        $error("bsq_tick_gen: W must be at least 2");
    end

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         wrap;

    // a period below two gives one tick every clock
    assign wrap  = (cnt_q >= i_period - W'(1)) || (i_period < W'(2));
    assign cnt_d = !i_en ? '0 : (wrap ? '0 : cnt_q + W'(1));

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q   <= '0;
            o_tick  <= 1'b0;
            o_level <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            o_tick  <= i_en && (cnt_q == '0);
            o_level <= i_en && (cnt_q < (i_period >> 1));
        end
    end

endmodule : bsq_tick_gen

`default_nettype wire

//--- src/bsq_core.sv
// What this block does
// - each accepted trigger releases the set cycle count, bounded by start/stop angle.
// - cycle count is programmed in half-cycle units.
// - after acceptance, wait the programmed start delay before oscillating.
// - start delay applies to every trigger source alike.
// - further triggers are ignored until the current burst completes.
// - source is the onboard periodic generator or outside input with chosen polarity.
// - second channel may take the first channel's selected trigger source.
// - manual key and remote triggers are accepted whichever source is selected.
// - the fired lamp lights when a trigger is received.
// - trigger burst is unavailable for noise or DC waveforms.
// - phase marker output rises at the waveform reference phase.
// - burst gate indicator is low while oscillating, high while stopped.
// - disabled auxiliary output is held low.
// - modulation choices only with internal modulation; else marker held low, waveform out gives secondary waveform.
// - stopped level follows angle unless override gives a percent of full scale.
// - with override on, start/stop angle still bounds each burst.
// - square with override gives three levels; without, low or high.
// - selecting trigger burst forces frequency lock off.
// - gate mode oscillates while gate on, stops at next start/stop angle.
// - half-cycle stop unit stops at angle or angle plus 180 degrees.
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`default_nettype none

module bsq_core
    import bsq_pkg::*;
#(
    parameter int unsigned PHASE_W = 32,
    parameter int unsigned CNT_W   = 32
) (
    // clock and reset
    input  wire logic               i_ref_clk,
    input  wire logic               i_rst_b,
    // ahb-lite slave
    input  wire logic               i_hsel,
    input  wire logic [31:0]        i_haddr,
    input  wire logic [1:0]         i_htrans,
    input  wire logic               i_hwrite,
    input  wire logic [2:0]         i_hsize,
    input  wire logic [31:0]        i_hwdata,
    input  wire logic               i_hready,
    output logic [31:0]             o_hrdata,
    output logic                    o_hreadyout,
    output logic                    o_hresp,
    // trigger pins
    input  wire logic               i_ext_trig,
    input  wire logic               i_manual_key,
    // shared source from the first channel
    input  wire logic               i_shared_evt,
    input  wire logic               i_shared_gate,
    // auxiliary waveform sources
    input  wire logic               i_mod_ref_marker,
    input  wire logic               i_modulation_waveform_out,
    input  wire logic               i_secondary_waveform_out,
    // oscillator outputs
    output logic [PHASE_W-1:0]      o_phase,
    output logic                    o_osc_run,
    output logic                    o_idle_force,
    output logic [7:0]              o_idle_pct,
    output logic                    o_aux,
    output logic                    o_fired_lamp,
    output logic                    o_freq_lock,
    // source shared to the second channel
    output logic                    o_src_evt,
    output logic                    o_src_gate
);

    if (PHASE_W != 32 || CNT_W < 2 || CNT_W > 32) begin : g_bad_param
        $error("bsq_core: PHASE_W must be 32 and CNT_W within 2..32");
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    typedef enum {ST_IDLE, ST_DELAY, ST_RUN} bsq_state_t;

    bsq_state_t         state_q;
    bsq_state_t         state_d;
    bsq_ctrl_t          ctrl_q;
    logic [PHASE_W-1:0] start_q;
    logic [PHASE_W-1:0] step_q;
    logic [CNT_W-1:0]   halves_q;
    logic [CNT_W-1:0]   delay_q;
    logic [CNT_W-1:0]   period_q;
    logic [7:0]         idle_q;
    logic [PHASE_W-1:0] ph_q;
    logic [PHASE_W-1:0] ph_d;
    logic [CNT_W-1:0]   rem_q;
    logic [CNT_W-1:0]   rem_d;
    logic [CNT_W-1:0]   dly_q;
    logic [CNT_W-1:0]   dly_d;
    logic               lamp_d;
    bsq_mode_t          run_mode_q;
    logic               wr_pend_q;
    logic [7:0]         wr_ofs_q;
    logic               remote_q;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire        addr_ph   = i_hsel && i_hready && i_htrans[1];
    wire        rd_take   = addr_ph && !i_hwrite;
    wire        wr_take   = addr_ph && i_hwrite;
    wire [7:0]  rd_ofs    = i_haddr[7:0];
    wire        hi_zero   = (i_haddr[31:8] == 24'h00_0000);
    wire        wr_ctrl   = wr_pend_q && (wr_ofs_q == BSQ_OFS_CTRL);
    wire        wr_start  = wr_pend_q && (wr_ofs_q == BSQ_OFS_START_PHASE);
    wire        wr_step   = wr_pend_q && (wr_ofs_q == BSQ_OFS_PHASE_STEP);
    wire        wr_halves = wr_pend_q && (wr_ofs_q == BSQ_OFS_HALVES);
    wire        wr_delay  = wr_pend_q && (wr_ofs_q == BSQ_OFS_START_DELAY);
    wire        wr_period = wr_pend_q && (wr_ofs_q == BSQ_OFS_TRIG_PERIOD);
    wire        wr_idle   = wr_pend_q && (wr_ofs_q == BSQ_OFS_IDLE_LEVEL);
    wire        wr_cmd    = wr_pend_q && (wr_ofs_q == BSQ_OFS_COMMAND);

    bsq_ctrl_t  ctrl_wr;
    always_comb begin
        ctrl_wr      = bsq_ctrl_t'(i_hwdata);
        ctrl_wr.rsvd = '0;
        if (ctrl_wr.pulse_group_type == BSQ_MODE_TRIG) begin
            ctrl_wr.freq_lock = 1'b0;
        end
    end

    wire [31:0] status_w = {28'h000_0000, (state_q == ST_DELAY), o_fired_lamp, o_osc_run,
                            (state_q != ST_IDLE)};

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hi_zero) begin
            case (rd_ofs)
                BSQ_OFS_CTRL:        rd_mux = ctrl_q;
                BSQ_OFS_START_PHASE: rd_mux = start_q;
                BSQ_OFS_PHASE_STEP:  rd_mux = step_q;
                BSQ_OFS_HALVES:      rd_mux = 32'(halves_q);
                BSQ_OFS_START_DELAY: rd_mux = 32'(delay_q);
                BSQ_OFS_TRIG_PERIOD: rd_mux = 32'(period_q);
                BSQ_OFS_IDLE_LEVEL:  rd_mux = {24'h00_0000, idle_q};
                BSQ_OFS_STATUS:      rd_mux = status_w;
                BSQ_OFS_REMAIN:      rd_mux = 32'(rem_q);
                default:             rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // trigger pin synchronisers
    // ------------------------------------------------------------------
    logic ext_s1;
    logic ext_s2;
    logic key_s1;
    logic key_s2;
    logic key_s3;
    logic ext_act_q;

    wire ext_act = (ctrl_q.ext_pol == BSQ_POL_RISE) ? ext_s2 :
                   (ctrl_q.ext_pol == BSQ_POL_FALL) ? !ext_s2 : 1'b0;
    wire ext_evt = ext_act && !ext_act_q;
    wire key_evt = key_s2 && !key_s3;

    // ------------------------------------------------------------------
    // trigger source selection
    // ------------------------------------------------------------------
    logic int_tick;
    logic int_level;

    bsq_tick_gen #(
        .W          (CNT_W)
    ) u_tick_gen (
        .i_ref_clk  (i_ref_clk),
        .i_rst_b    (i_rst_b),
        .i_en       (ctrl_q.src == BSQ_SRC_INT),
        .i_period   (period_q),
        .o_tick     (int_tick),
        .o_level    (int_level)
    );

    wire own_evt  = (ctrl_q.src == BSQ_SRC_INT) ? int_tick :
                    (ctrl_q.src == BSQ_SRC_EXT) ? ext_evt : 1'b0;
    wire own_lvl  = (ctrl_q.src == BSQ_SRC_INT) ? int_level :
                    (ctrl_q.src == BSQ_SRC_EXT) ? ext_act : 1'b0;
    wire shared   = (ctrl_q.src == BSQ_SRC_FIRST_CHANNEL_SHARED);
    wire sel_evt  = shared ? i_shared_evt : own_evt;
    wire sel_lvl  = shared ? i_shared_gate : own_lvl;
    // one merged event feeds the same delay path for every source
    wire trig_evt = sel_evt || key_evt || remote_q;
    wire gate_on  = sel_lvl || key_s2 || remote_q;

    // ------------------------------------------------------------------
    // phase crossings
    // ------------------------------------------------------------------
    wire [PHASE_W-1:0] rel     = ph_q - start_q;
    wire [PHASE_W:0]   rel_sum = {1'b0, rel} + {1'b0, step_q};
    wire               x_full  = rel_sum[PHASE_W];
    wire               x_half  = !rel[PHASE_W-1] && rel_sum[PHASE_W-1];
    wire               x_any   = x_full || x_half;
    wire [PHASE_W-1:0] ph_step = ph_q + step_q;

    wire mode_trig  = (ctrl_q.pulse_group_type == BSQ_MODE_TRIG);
    wire mode_gate  = (ctrl_q.pulse_group_type == BSQ_MODE_GATE);
    wire mode_cont  = (ctrl_q.pulse_group_type == BSQ_MODE_CONT);
    wire wave_noise = (ctrl_q.wave == BSQ_WAVE_NOISE);
    wire wave_dc    = (ctrl_q.wave == BSQ_WAVE_DC);
    wire trig_ok    = !wave_noise && !wave_dc;
    wire gate_stop  = ctrl_q.half_stop ? x_any : x_full;
    wire mode_moved = (ctrl_q.pulse_group_type != run_mode_q);

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        ph_d    = ph_q;
        rem_d   = rem_q;
        dly_d   = dly_q;
        lamp_d  = o_fired_lamp;
        case (state_q)
            ST_IDLE: begin
                ph_d   = start_q;
                lamp_d = 1'b0;
                if (mode_cont && !wave_dc) begin
                    state_d = ST_RUN;
                end else if (mode_trig && trig_ok && trig_evt && (halves_q != '0)) begin
                    lamp_d = 1'b1;
                    rem_d  = halves_q;
                    dly_d  = delay_q;
                    state_d = (delay_q == '0) ? ST_RUN : ST_DELAY;
                end else if (mode_gate && !wave_dc && gate_on) begin
                    lamp_d  = 1'b1;
                    state_d = ST_RUN;
                end
            end
            ST_DELAY: begin
                // triggers arriving here are dropped
                dly_d = dly_q - CNT_W'(1);
                if (mode_moved) begin
                    state_d = ST_IDLE;
                end else if (dly_q <= CNT_W'(1)) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                ph_d = ph_step;
                if (mode_moved) begin
                    state_d = ST_IDLE;
                    ph_d    = start_q;
                end else if (run_mode_q == BSQ_MODE_TRIG) begin
                    if (x_any) begin
                        rem_d = rem_q - CNT_W'(1);
                        if (rem_q <= CNT_W'(1)) begin
                            state_d = ST_IDLE;
                            ph_d    = start_q;
                        end
                    end
                end else if (run_mode_q == BSQ_MODE_GATE) begin
                    lamp_d = gate_on;
                    // noise has no phase, so it stops on the gate itself
                    if (!gate_on && (wave_noise || gate_stop)) begin
                        state_d = ST_IDLE;
                        ph_d    = start_q;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    wire running_d = (state_d == ST_RUN);

    // ------------------------------------------------------------------
    // auxiliary output selection
    // ------------------------------------------------------------------
    logic aux_d;
    always_comb begin
        case (ctrl_q.aux_output_select)
            BSQ_AUX_PHASE_MARK:            aux_d = !ph_d[PHASE_W-1];
            BSQ_AUX_BURST_GATE_INDICATOR:  aux_d = !running_d;
            BSQ_AUX_MODULATION_REF_MARKER: aux_d = ctrl_q.mod_int_on &&
                                                   i_mod_ref_marker;
            BSQ_AUX_WAVEFORM_OUT:          aux_d = ctrl_q.mod_int_on ?
                                                   i_modulation_waveform_out :
                                                   i_secondary_waveform_out;
            BSQ_AUX_OFF:                   aux_d = 1'b0;
            default:                       aux_d = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // flip-flops: bus and configuration
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_pend_q   <= 1'b0;
            wr_ofs_q    <= 8'h00;
            o_hrdata    <= 32'h0000_0000;
            o_hreadyout <= 1'b0;
            o_hresp     <= 1'b0;
        end else begin
            wr_pend_q   <= wr_take && hi_zero;
            wr_ofs_q    <= rd_ofs;
            o_hrdata    <= rd_take ? rd_mux : 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_q   <= bsq_ctrl_t'(BSQ_RST_CTRL);
            start_q  <= BSQ_RST_START_PHASE;
            step_q   <= BSQ_RST_PHASE_STEP;
            halves_q <= CNT_W'(BSQ_RST_HALVES);
            delay_q  <= CNT_W'(BSQ_RST_START_DELAY);
            period_q <= CNT_W'(BSQ_RST_TRIG_PERIOD);
            idle_q   <= BSQ_RST_IDLE_LEVEL;
            remote_q <= 1'b0;
        end else begin
            if (wr_ctrl)   ctrl_q   <= ctrl_wr;
            if (wr_start)  start_q  <= i_hwdata;
            if (wr_step)   step_q   <= i_hwdata;
            if (wr_halves) halves_q <= i_hwdata[CNT_W-1:0];
            if (wr_delay)  delay_q  <= i_hwdata[CNT_W-1:0];
            if (wr_period) period_q <= i_hwdata[CNT_W-1:0];
            if (wr_idle)   idle_q   <= i_hwdata[7:0];
            remote_q <= wr_cmd && i_hwdata[BSQ_CMD_REMOTE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // flip-flops: synchronisers and source sharing
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ext_s1     <= 1'b0;
            ext_s2     <= 1'b0;
            key_s1     <= 1'b0;
            key_s2     <= 1'b0;
            key_s3     <= 1'b0;
            ext_act_q  <= 1'b0;
            o_src_evt  <= 1'b0;
            o_src_gate <= 1'b0;
        end else begin
            ext_s1     <= i_ext_trig;
            ext_s2     <= ext_s1;
            key_s1     <= i_manual_key;
            key_s2     <= key_s1;
            key_s3     <= key_s2;
            ext_act_q  <= ext_act;
            o_src_evt  <= own_evt;
            o_src_gate <= own_lvl;
        end
    end

    // ------------------------------------------------------------------
    // flip-flops: sequencer and outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q    <= ST_IDLE;
            run_mode_q <= BSQ_MODE_CONT;
            ph_q       <= '0;
            rem_q      <= '0;
            dly_q      <= '0;
        end else begin
            state_q <= state_d;
            ph_q    <= ph_d;
            rem_q   <= rem_d;
            dly_q   <= dly_d;
            if (state_q == ST_IDLE) begin
                run_mode_q <= ctrl_q.pulse_group_type;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_phase      <= '0;
            o_osc_run    <= 1'b0;
            o_idle_force <= 1'b0;
            o_idle_pct   <= BSQ_RST_IDLE_LEVEL;
            o_aux        <= 1'b0;
            o_fired_lamp <= 1'b0;
            o_freq_lock  <= 1'b0;
        end else begin
            o_phase      <= ph_d;
            o_osc_run    <= running_d;
            o_idle_force <= !running_d && ctrl_q.idle_level_override;
            o_idle_pct   <= idle_q;
            o_aux        <= aux_d;
            o_fired_lamp <= lamp_d && (state_d != ST_IDLE);
            o_freq_lock  <= ctrl_q.freq_lock && !mode_trig;
        end
    end

endmodule : bsq_core

`default_nettype wire

//--- bench/bsq_core_asserts.sv
`default_nettype none
// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module bsq_core_asserts #(parameter int unsigned PHASE_W = 32) (
    input wire logic               i_ref_clk, i_rst_b, i_hsel, i_hwrite, i_hready,
    input wire logic [1:0]         i_htrans,
    input wire logic [31:0]        o_hrdata,
    input wire logic               o_hreadyout, o_hresp, o_osc_run, o_idle_force,
    input wire logic               o_fired_lamp, o_src_evt,
    input wire logic [PHASE_W-1:0] o_phase
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    wire logic rd_req = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
    sequence s_stop; o_osc_run ##1 !o_osc_run; endsequence
    sequence s_idle2; !o_osc_run [*2]; endsequence
    property p_rdy; $past(i_rst_b) |-> o_hreadyout; endproperty
    a_rdy: assert property (p_rdy) else $error("hreadyout low");
    property p_okay; o_hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("hresp not okay");
    property p_rdata; !$past(rd_req) |-> o_hrdata == 32'h0; endproperty
    a_rdata: assert property (p_rdata) else $error("hrdata not zero");
    property p_idle; o_idle_force |-> !o_osc_run; endproperty
    a_idle: assert property (p_idle) else $error("idle level while running");
    property p_hold; s_idle2 |-> $stable(o_phase); endproperty
    a_hold: assert property (p_hold) else $error("phase moved while stopped");
    property p_move; o_osc_run [*2] |-> o_phase != $past(o_phase); endproperty
    a_move: assert property (p_move) else $error("phase stuck while running");
    property p_lamp; s_stop |-> !o_fired_lamp; endproperty
    a_lamp: assert property (p_lamp) else $error("lamp on after burst end");
    property p_evt; o_src_evt |=> !o_src_evt; endproperty
    a_evt: assert property (p_evt) else $error("source event too long");
endmodule : bsq_core_asserts
bind bsq_core bsq_core_asserts #(.PHASE_W(PHASE_W)) u_bsq_core_asserts (.i_ref_clk, .i_rst_b,
    .i_hsel, .i_hwrite, .i_hready, .i_htrans, .o_hrdata, .o_hreadyout, .o_hresp, .o_osc_run,
    .o_idle_force, .o_fired_lamp, .o_src_evt, .o_phase);
`default_nettype wire

//--- bench/bsq_trig_src.sv
`default_nettype none
// ---------------------------------------------------------------
// outside trigger source, fixed-width pulse per request
// ---------------------------------------------------------------
module bsq_trig_src (
    input  wire logic i_ref_clk,
    input  wire logic i_fire,
    output logic      o_ext_trig
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] width_q = 3'h0;
    always @(posedge i_ref_clk) width_q <= i_fire ? 3'h6 : width_q - 3'(width_q != 3'h0);
    assign o_ext_trig = (width_q != 3'h0);
endmodule : bsq_trig_src
`default_nettype wire

//--- bench/tb.sv
`default_nettype none
module tb import bsq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_b = 1'b0, hsel = 1'b1, hwrite = 1'b0, man = 1'b0, shev = 1'b0;
    logic        fire = 1'b0, sec = 1'b0, rdy, hresp, ext, run, idle, aux, lamp, lock;
    logic [1:0]  htrans = 2'h0;
    logic [7:0]  pct;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    int          err_total = 0, check_count = 0;
    bsq_core u_bsq_core (.i_ref_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(rdy), .o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(hresp),
        .i_ext_trig(ext), .i_manual_key(man), .i_shared_evt(shev), .i_shared_gate(1'b0),
        .i_mod_ref_marker(1'b0), .i_modulation_waveform_out(1'b0),
        .i_secondary_waveform_out(sec), .o_phase(), .o_osc_run(run), .o_idle_force(idle),
        .o_idle_pct(pct), .o_aux(aux), .o_fired_lamp(lamp), .o_freq_lock(lock),
        .o_src_evt(), .o_src_gate());
    bsq_trig_src u_bsq_trig_src (.i_ref_clk(clk), .i_fire(fire), .o_ext_trig(ext));
    task automatic test_done;
        if (err_total == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task automatic wrdy;
        int n = 0;
        do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 50);
        if (n >= 50) begin err_total++; test_done; end
    endtask : wrdy
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, e);
        @(posedge clk);
        htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        wrdy;
        htrans <= 2'h0; hwdata <= d;
        wrdy;
        if (!w) chk("rdata", hrdata, e);
    endtask : acc
    // wait for the lamp, then measure start delay and run length
    task automatic burst(input int d, h);
        int n = 0;
        int c = 0;
        while (lamp !== 1'b1 && n < 300) begin @(posedge clk); n++; end
        while (run !== 1'b1 && c < 300) begin @(posedge clk); c++; end
        chk("delay", c, d);
        chk("aux", aux, 1'b0);
        c = 0;
        while (run === 1'b1 && c < 300) begin @(posedge clk); c++; end
        chk("halves", c, 2 * h);
        if (n >= 300 || c >= 300) begin err_total++; test_done; end
    endtask : burst
    task automatic quiet(input int k);
        int r = 0;
        repeat (k) begin @(posedge clk); r += (run !== 1'b0); end
        chk("quiet", r, 0);
    endtask : quiet
    initial forever #5 clk = ~clk;
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        acc(0, BSQ_OFS_CTRL, 0, BSQ_RST_CTRL);
        acc(0, BSQ_OFS_HALVES, 0, BSQ_RST_HALVES);
        acc(0, BSQ_OFS_TRIG_PERIOD, 0, BSQ_RST_TRIG_PERIOD);
        acc(0, 8'h30, 0, 0);
        acc(1, BSQ_OFS_PHASE_STEP, 32'h4000_0000, 0);
        acc(1, BSQ_OFS_HALVES, 32'h3, 0);
        acc(1, BSQ_OFS_START_DELAY, 32'h4, 0);
        acc(1, BSQ_OFS_CTRL, 32'h805, 0);
        acc(1, BSQ_OFS_COMMAND, 32'h1, 0);
        man <= 1'b1;
        burst(4, 3);
        quiet(30);
        man <= 1'b0;
        quiet(8);
        man <= 1'b1;
        burst(4, 3);
        acc(1, BSQ_OFS_CTRL, 32'h815, 0);
        fire <= 1'b1;
        @(posedge clk) fire <= 1'b0;
        burst(4, 3);
        acc(1, BSQ_OFS_TRIG_PERIOD, 32'h28, 0);
        acc(1, BSQ_OFS_CTRL, 32'h801, 0);
        burst(4, 3);
        acc(1, BSQ_OFS_CTRL, 32'h809, 0);
        shev <= 1'b1;
        @(posedge clk) shev <= 1'b0;
        burst(4, 3);
        acc(1, BSQ_OFS_CTRL, 32'h845, 0);
        acc(1, BSQ_OFS_IDLE_LEVEL, 32'hCE, 0);
        repeat (20) @(posedge clk);
        chk("force", idle, 1'b1);
        chk("pct", pct, 8'hCE);
        chk("aux", aux, 1'b1);
        acc(1, BSQ_OFS_CTRL, 32'hE05, 0);
        acc(1, BSQ_OFS_COMMAND, 32'h1, 0);
        quiet(20);
        acc(1, BSQ_OFS_CTRL, 32'h8805, 0);
        acc(0, BSQ_OFS_CTRL, 0, 32'h805);
        chk("lock", lock, 1'b0);
        acc(1, BSQ_OFS_CTRL, 32'h8800, 0);
        repeat (2) @(posedge clk);
        chk("lock", lock, 1'b1);
        acc(1, BSQ_OFS_CTRL, 32'h2005, 0);
        repeat (2) @(posedge clk);
        chk("aux", aux, 1'b0);
        sec <= 1'b1;
        acc(1, BSQ_OFS_CTRL, 32'h1805, 0);
        repeat (2) @(posedge clk);
        chk("aux", aux, 1'b1);
        acc(1, BSQ_OFS_CTRL, 32'h806, 0);
        repeat (3) @(posedge clk);
        chk("gate", run, 1'b1);
        man <= 1'b0;
        repeat (12) @(posedge clk);
        chk("gate", run, 1'b0);
        test_done;
    end
endmodule : tb
`default_nettype wire
